// ==== hdl/btg_pkg.sv ====
// Constants and types for the tone generator block
package btg_pkg;
  localparam logic [6:0]  ADDR_TONE_CONTROL   = 7'h47;
  localparam logic [6:0]  ADDR_RESERVED       = 7'h48;
  localparam logic [6:0]  ADDR_LENGTH_HIGH    = 7'h49;
  localparam logic [6:0]  ADDR_LENGTH_MIDDLE  = 7'h4a;
  localparam logic [6:0]  ADDR_LENGTH_LOW     = 7'h4b;
  localparam logic [6:0]  ADDR_SINE_HIGH      = 7'h4c;
  localparam logic [6:0]  ADDR_SINE_LOW       = 7'h4d;
  localparam logic [6:0]  ADDR_COSINE_HIGH    = 7'h4e;
  localparam logic [6:0]  ADDR_COSINE_LOW     = 7'h4f;
  localparam int          ENABLE_BIT          = 7;
  localparam int          LEVEL_MSB           = 5;
  localparam logic [7:0]  RST_TONE_CONTROL    = 8'h00;
  localparam logic [7:0]  RST_LENGTH_HIGH     = 8'h00;
  localparam logic [7:0]  RST_LENGTH_MIDDLE   = 8'h00;
  localparam logic [7:0]  RST_LENGTH_LOW      = 8'hee;
  localparam logic [7:0]  RST_SINE_HIGH       = 8'h10;
  localparam logic [7:0]  RST_SINE_LOW        = 8'hd8;
  localparam logic [7:0]  RST_COSINE_HIGH     = 8'h7e;
  localparam logic [7:0]  RST_COSINE_LOW      = 8'he3;
  // Level code 0 is +2 dB; codes below 2 add gain above unity
  localparam logic [5:0]  LEVEL_UNITY_CODE    = 6'h02;
  // 10^(-1/20) in Q1.15 (-1 dB)
  localparam logic [15:0] DB_STEP_Q15         = 16'h7214;
  // 10^(2/20) in Q2.14 (+2 dB)
  localparam logic [15:0] TOP_GAIN_Q14        = 16'h5094;
  typedef enum logic [1:0] {BTG_IDLE, BTG_RUN} btg_state_type;
endpackage

// ==== hdl/btg_tone_generator.sv ====
// Sine tone generator with its register file, one sample per DAC word clock
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
// Operation
// R1 - Setting the enable bit starts a tone, the block clears it itself when the duration ends, and zero keeps it idle.
// R2 - The 6-bit level code gives +2 dB at zero and 1 dB less per step down to -61 dB.
// R3 - The duration is a 24-bit sample count from high, middle and low byte registers.
// R4 - After reset the duration bytes read 0x00, 0x00 and 0xee.
// R5 - A 16-bit sine coefficient in two bytes resets to 0x10d8.
// R6 - A 16-bit cosine coefficient in two bytes resets to 0x7ee3.
// R7 - Tones run only while the tone-capable processing mode is selected.
// R8 - Software writes zero to the reserved control bit and the reserved register.
// R9 - One sample per sample period from a recursive oscillator while the count runs down.
module btg_tone_generator
  import btg_pkg::*;
(
  input  wire logic              sys_clk_in,
  input  wire logic              rst_in,
  input  wire logic              reg_write_in,
  input  wire logic              reg_read_in,
  input  wire logic [6:0]        reg_addr_in,
  input  wire logic [7:0]        reg_wdata_in,
  output logic      [7:0]        reg_rdata_out,
  input  wire logic              sample_tick_in,
  input  wire logic              tone_capable_processing_mode_in,
  output logic signed [15:0]     tone_sample_out,
  output logic                   tone_valid_out,
  output logic                   tone_active_out
);
  //////////////////////////////////////////////////////////////////////////////
  logic [7:0]  tone_control;
  logic [7:0]  reserved_reg;
  logic [7:0]  length_high, length_middle, length_low;
  logic [7:0]  sine_high, sine_low, cosine_high, cosine_low;
  btg_state_type state;
  logic [23:0] remaining;
  logic signed [15:0] osc_now, osc_prev;
  logic signed [15:0] level_gain;
  logic        done_pulse;
  logic        ctrl_write;
  logic        start;
  logic [5:0]  level_code;
  logic        enable_bit;
  logic        wr_reserved;
  logic        wr_length_high;
  logic        wr_length_middle;
  logic        wr_length_low;
  logic        wr_sine_high;
  logic        wr_sine_low;
  logic        wr_cosine_high;
  logic        wr_cosine_low;
  logic [7:0]  next_rdata;

  assign ctrl_write = reg_write_in && (reg_addr_in == ADDR_TONE_CONTROL);
  assign start      = ctrl_write && reg_wdata_in[ENABLE_BIT] && tone_capable_processing_mode_in; // R1 R7

  //////////////////////////////////////////////////////////////////////////////
  // Register write strobes, one per register
  assign wr_reserved      = reg_write_in && (reg_addr_in == ADDR_RESERVED); // R8
  assign wr_length_high   = reg_write_in && (reg_addr_in == ADDR_LENGTH_HIGH);
  assign wr_length_middle = reg_write_in && (reg_addr_in == ADDR_LENGTH_MIDDLE);
  assign wr_length_low    = reg_write_in && (reg_addr_in == ADDR_LENGTH_LOW);
  assign wr_sine_high     = reg_write_in && (reg_addr_in == ADDR_SINE_HIGH);
  assign wr_sine_low      = reg_write_in && (reg_addr_in == ADDR_SINE_LOW);
  assign wr_cosine_high   = reg_write_in && (reg_addr_in == ADDR_COSINE_HIGH);
  assign wr_cosine_low    = reg_write_in && (reg_addr_in == ADDR_COSINE_LOW);

  // Bit 6 has no storage and reads zero, so a stray write cannot leak into it
  assign tone_control = {enable_bit, 1'b0, level_code}; // R8

  //////////////////////////////////////////////////////////////////////////////
  // Level code of the control register
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      level_code <= RST_TONE_CONTROL[LEVEL_MSB:0];
    end else if (ctrl_write) begin
      level_code <= reg_wdata_in[LEVEL_MSB:0]; // R2
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Enable bit: a write is the only setter, so a write beats the done pulse
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      enable_bit <= RST_TONE_CONTROL[ENABLE_BIT];
    end else if (ctrl_write) begin
      // A write of one outside the tone mode is not kept, so the bit never lies
      enable_bit <= start; // R1 R7
    end else if (done_pulse) begin
      enable_bit <= 1'b0; // R1
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Reserved register keeps what is written; software is expected to leave it zero
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      reserved_reg <= 8'h00;
    end else if (wr_reserved) begin
      reserved_reg <= reg_wdata_in; // R8
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Duration bytes, taken as one count only when a tone starts
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      length_high   <= RST_LENGTH_HIGH; // R4
      length_middle <= RST_LENGTH_MIDDLE; // R4
      length_low    <= RST_LENGTH_LOW; // R4
    end else begin
      if (wr_length_high) begin
        length_high <= reg_wdata_in; // R3
      end
      if (wr_length_middle) begin
        length_middle <= reg_wdata_in; // R3
      end
      if (wr_length_low) begin
        length_low <= reg_wdata_in; // R3
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sine coefficient bytes
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sine_high <= RST_SINE_HIGH; // R5
      sine_low  <= RST_SINE_LOW; // R5
    end else begin
      if (wr_sine_high) begin
        sine_high <= reg_wdata_in; // R5
      end
      if (wr_sine_low) begin
        sine_low <= reg_wdata_in; // R5
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Cosine coefficient bytes; a change mid-tone bends the running oscillator
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cosine_high <= RST_COSINE_HIGH; // R6
      cosine_low  <= RST_COSINE_LOW; // R6
    end else begin
      if (wr_cosine_high) begin
        cosine_high <= reg_wdata_in; // R6
      end
      if (wr_cosine_low) begin
        cosine_low <= reg_wdata_in; // R6
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read select; unmapped addresses read zero
  always_comb begin
    next_rdata = 8'h00;
    unique case (reg_addr_in)
      ADDR_TONE_CONTROL:  next_rdata = tone_control;
      ADDR_RESERVED:      next_rdata = reserved_reg;
      ADDR_LENGTH_HIGH:   next_rdata = length_high;
      ADDR_LENGTH_MIDDLE: next_rdata = length_middle;
      ADDR_LENGTH_LOW:    next_rdata = length_low;
      ADDR_SINE_HIGH:     next_rdata = sine_high;
      ADDR_SINE_LOW:      next_rdata = sine_low;
      ADDR_COSINE_HIGH:   next_rdata = cosine_high;
      ADDR_COSINE_LOW:    next_rdata = cosine_low;
      default:            next_rdata = 8'h00;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read port: registered, one cycle after the strobe, held until the next read
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_read_in) begin
      reg_rdata_out <= next_rdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Level code to linear gain in Q2.14, one multiply per code step
  // Unrolls into a deep multiplier chain; the code changes rarely, so depth was traded for no table
  always_comb begin
    logic [31:0] acc;
    acc = {16'h0000, TOP_GAIN_Q14};
    for (int i = 0; i < 64; i++) begin
      if (i < int'(tone_control[LEVEL_MSB:0])) begin
        acc = ((acc * {16'h0000, DB_STEP_Q15}) >> 15); // R2
      end
    end
    level_gain = signed'(acc[15:0]);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer and count-down; leaving the mode stops a running tone at once
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state      <= BTG_IDLE;
      remaining  <= 24'h000000;
      done_pulse <= 1'b0;
    end else begin
      done_pulse <= 1'b0;
      unique case (state)
        BTG_IDLE: begin
          if (start && ({length_high, length_middle, length_low} != 24'h000000)) begin
            state     <= BTG_RUN;
            remaining <= {length_high, length_middle, length_low}; // R3 R9
          end else if (start) begin
            done_pulse <= 1'b1; // R1
          end
        end
        BTG_RUN: begin
          if (!tone_capable_processing_mode_in || (ctrl_write && !reg_wdata_in[ENABLE_BIT])) begin
            state      <= BTG_IDLE; // R1 R7
            done_pulse <= !tone_capable_processing_mode_in;
          end else if (sample_tick_in) begin
            remaining <= remaining - 24'h000001; // R9
            if (remaining == 24'h000001) begin
              state      <= BTG_IDLE;
              done_pulse <= 1'b1; // R1
            end
          end
        end
        default: state <= BTG_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Recursive oscillator y[n] = 2c*y[n-1] - y[n-2], seeded with sine coefficient
  // Saturation keeps a coefficient pair slightly off the unit circle from wrapping
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    logic signed [33:0] prod;
    logic signed [33:0] nxt;
    if (rst_in) begin
      osc_now  <= 16'sh0000;
      osc_prev <= 16'sh0000;
    end else if (state == BTG_IDLE) begin
      osc_now  <= signed'({sine_high, sine_low}); // R5
      osc_prev <= 16'sh0000;
    end else if (sample_tick_in) begin
      prod = 34'(osc_now) * 34'(signed'({cosine_high, cosine_low})); // R6 R9
      nxt  = (prod >>> 14) - 34'(osc_prev);
      if (nxt > 34'sh0_7fff) begin
        nxt = 34'sh0_7fff;
      end else if (nxt < -34'sh0_8000) begin
        nxt = -34'sh0_8000;
      end
      osc_prev <= osc_now;
      osc_now  <= nxt[15:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Active flag follows the sequencer one cycle late
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      tone_active_out <= 1'b0;
    end else begin
      tone_active_out <= (state == BTG_RUN); // R1
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // One valid pulse per tick while running; the mode term drops the pulse
  // in the cycle the mode goes away, before the sequencer has reacted
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      tone_valid_out <= 1'b0;
    end else begin
      tone_valid_out <= (state == BTG_RUN) && sample_tick_in && tone_capable_processing_mode_in; // R9
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Scaled, saturated sample; it holds between ticks and rests at zero when idle
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    logic signed [31:0] scaled;
    if (rst_in) begin
      tone_sample_out <= 16'sh0000;
    end else if ((state == BTG_RUN) && sample_tick_in) begin
      scaled = (32'(osc_now) * 32'(level_gain)) >>> 14; // R2
      if (scaled > 32'sh0000_7fff) begin
        tone_sample_out <= 16'sh7fff;
      end else if (scaled < -32'sh0000_8000) begin
        tone_sample_out <= -16'sh8000;
      end else begin
        tone_sample_out <= scaled[15:0];
      end
    end else if (state == BTG_IDLE) begin
      tone_sample_out <= 16'sh0000;
    end
  end
endmodule

// ==== tb/btg_checker.sv ====
// Port assertions for the tone generator
`timescale 1ns/1ns
module btg_checker
  import btg_pkg::*;
(
  input wire logic               sys_clk_in,
  input wire logic               rst_in,
  input wire logic               reg_write_in,
  input wire logic               reg_read_in,
  input wire logic [6:0]         reg_addr_in,
  input wire logic [7:0]         reg_wdata_in,
  input wire logic [7:0]         reg_rdata_out,
  input wire logic               sample_tick_in,
  input wire logic               tone_capable_processing_mode_in,
  input wire logic signed [15:0] tone_sample_out,
  input wire logic               tone_valid_out,
  input wire logic               tone_active_out
);
  logic mode;
  logic ctl_wr;
  assign mode = tone_capable_processing_mode_in;
  assign ctl_wr = reg_write_in && reg_addr_in == ADDR_TONE_CONTROL;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  property p_valid_run; tone_valid_out |-> tone_active_out || $past(tone_active_out); endproperty
  a_valid_run: assert property (p_valid_run) else $error("sample outside a tone");
  property p_tick_cause; !sample_tick_in |=> !tone_valid_out; endproperty
  a_tick_cause: assert property (p_tick_cause) else $error("sample without tick");
  property p_mode_stop; !mode |-> ##2 !tone_active_out; endproperty
  a_mode_stop: assert property (p_mode_stop) else $error("tone without mode");
  property p_start; ctl_wr && reg_wdata_in[ENABLE_BIT] && mode ##1 mode |-> ##1 tone_active_out; endproperty
  a_start: assert property (p_start) else $error("tone did not start");
  property p_stop; ctl_wr && !reg_wdata_in[ENABLE_BIT] |-> ##2 !tone_active_out; endproperty
  a_stop: assert property (p_stop) else $error("tone did not stop");
  property p_rsvd_read; reg_read_in && reg_addr_in == ADDR_RESERVED |=> reg_rdata_out == 8'h00; endproperty
  a_rsvd_read: assert property (p_rsvd_read) else $error("reserved reads nonzero");
  property p_bit6_zero; reg_read_in && reg_addr_in == ADDR_TONE_CONTROL |=> !reg_rdata_out[6]; endproperty
  a_bit6_zero: assert property (p_bit6_zero) else $error("bit 6 reads one");
  property p_rdata_hold; !reg_read_in |=> $stable(reg_rdata_out); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
endmodule
bind btg_tone_generator btg_checker chk (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .reg_write_in(reg_write_in),
  .reg_read_in(reg_read_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
  .sample_tick_in(sample_tick_in), .tone_capable_processing_mode_in(tone_capable_processing_mode_in),
  .tone_sample_out(tone_sample_out), .tone_valid_out(tone_valid_out), .tone_active_out(tone_active_out));

// ==== tb/btg_word_clock.sv ====
// Word clock source: one sample tick every DIV system clocks
`timescale 1ns/1ns
module btg_word_clock #(parameter int DIV = 4) (
  input  wire logic clk_in,
  input  wire logic rst_in,
  output logic      tick_out
);
  logic [7:0] cnt;
  // Ticks never come back to back while DIV is 2 or more, as from a real word clock
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) cnt <= 8'h00;
    else cnt <= (cnt == 8'(DIV - 1)) ? 8'h00 : cnt + 8'h01;
  end
  assign tick_out = cnt == 8'(DIV - 1);
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the tone generator
`timescale 1ns/1ns
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin num_errors++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module testbench
  import btg_pkg::*;
  ;
  logic clk, rst, we, re, mode, tick, valid, active;
  logic [6:0] addr;
  logic [7:0] wd, rdata;
  logic signed [15:0] smp, first;
  int num_errors = 0, total_checks = 0, n;
  logic [7:0] rv [9] = '{RST_TONE_CONTROL, 8'h00, RST_LENGTH_HIGH, RST_LENGTH_MIDDLE, RST_LENGTH_LOW,
                         RST_SINE_HIGH, RST_SINE_LOW, RST_COSINE_HIGH, RST_COSINE_LOW};
  btg_word_clock #(.DIV(4)) word_clock (.clk_in(clk), .rst_in(rst), .tick_out(tick));
  btg_tone_generator dut (.sys_clk_in(clk), .rst_in(rst), .reg_write_in(we), .reg_read_in(re), .reg_addr_in(addr),
    .reg_wdata_in(wd), .reg_rdata_out(rdata), .sample_tick_in(tick), .tone_capable_processing_mode_in(mode),
    .tone_sample_out(smp), .tone_valid_out(valid), .tone_active_out(active));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task summarize();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    we <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    we <= 1'b0;
  endtask
  task rd(input logic [6:0] a, input logic [7:0] e);
    @(posedge clk);
    re <= 1'b1;
    addr <= a;
    @(posedge clk);
    re <= 1'b0;
    @(posedge clk);
    `CHK(rdata, e)
  endtask
  // Counts samples until the tone ends; a tone that never ends is a failure
  task run(input logic [7:0] ctl);
    int i;
    logic seen;
    n = 0;
    seen = 1'b0;
    wr(ADDR_TONE_CONTROL, ctl);
    for (i = 0; i < 4000; i++) begin
      @(posedge clk);
      #1;
      if (valid === 1'b1) n++;
      if (n == 1 && valid === 1'b1) first = smp;
      if (active === 1'b1) seen = 1'b1;
      else if (seen) break;
    end
    if (i == 4000) begin
      `CHK(1'b0, 1'b1)
      summarize();
    end
  endtask
  task reset_values();
    for (int k = 0; k < 9; k++) rd(ADDR_TONE_CONTROL + 7'(k), rv[k]);
    rd(7'h50, 8'h00);
  endtask
  task full_tone();
    wr(ADDR_LENGTH_MIDDLE, 8'h01);
    wr(ADDR_LENGTH_LOW, 8'h02);
    wr(ADDR_SINE_HIGH, 8'h20);
    wr(ADDR_SINE_LOW, 8'h00);
    run({2'b10, LEVEL_UNITY_CODE});
    `CHK(n, 258)
    `CHK(first, 16'sh2000)
    rd(ADDR_TONE_CONTROL, {2'b00, LEVEL_UNITY_CODE});
  endtask
  task levels();
    wr(ADDR_LENGTH_MIDDLE, 8'h00);
    run(8'h80);
    `CHK(first > 16'sh2000, 1'b1)
    run(8'hbf);
    `CHK(first < 16'sh0010 && first > 0, 1'b1)
  endtask
  task mode_off();
    mode <= 1'b0;
    wr(ADDR_TONE_CONTROL, 8'h80);
    rd(ADDR_TONE_CONTROL, 8'h00);
    `CHK(active, 1'b0)
    mode <= 1'b1;
  endtask
  task stop_early();
    wr(ADDR_LENGTH_MIDDLE, 8'h01);
    wr(ADDR_TONE_CONTROL, 8'h80);
    repeat (20) @(posedge clk);
    `CHK(active, 1'b1)
    wr(ADDR_TONE_CONTROL, 8'h00);
    repeat (2) @(posedge clk);
    `CHK(active, 1'b0)
  endtask
  initial begin
    {rst, we, re, mode} = 4'b1001;
    addr = 7'h00;
    wd = 8'h00;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    reset_values();
    full_tone();
    levels();
    mode_off();
    stop_early();
    summarize();
  end
endmodule
